// File: rtl/dacss_defs.vh
/*
 * Constants for the accumulator store path and barrel shifter:
 * widths, operation codes, rounding and saturation values.
 * Assumes it is included by bare name from every design file.
 */
`ifndef DACSS_DEFS_VH
`define DACSS_DEFS_VH

`define DACSS_ACC_W 40
`define DACSS_WORD_W 16
`define DACSS_OP_W 4
`define DACSS_SHAMT_W 6

// operation codes presented by instruction decode
`define DACSS_OP_NONE 4'h0
`define DACSS_OP_STORE_TRUNC 4'h1
`define DACSS_OP_STORE_ROUND 4'h2
`define DACSS_OP_MAC 4'h3
`define DACSS_OP_PLAIN_MULTIPLY 4'h4
`define DACSS_OP_NEGATED_MULTIPLY 4'h5
`define DACSS_OP_SQUARED_DISTANCE 4'h6
`define DACSS_OP_SQUARED_DISTANCE_ACC 4'h7
`define DACSS_OP_SHIFT_ACC 4'h8
`define DACSS_OP_SHIFT_XBUS 4'h9

// write-back addressing modes
`define DACSS_WB_DIRECT 1'b0
`define DACSS_WB_POSTINC 1'b1

// round and saturation values
`define DACSS_ROUND_HALF 16'h8000
`define DACSS_SAT_POS 16'h7FFF
`define DACSS_SAT_NEG 16'h8000
`define DACSS_ACC_SIGN_BIT 39
`define DACSS_HI_MSB 31
`define DACSS_HI_LSB 16
`define DACSS_RANGE_MSB 23
`define DACSS_RANGE_LSB 15

// pointer and shifter
`define DACSS_PTR_STEP 16'h0002
`define DACSS_PTR_RESET 16'h0000
`define DACSS_SHIFT_MAX 6'h10
`define DACSS_XR_LSB 16

`endif

// File: rtl/dacss_round_sat.v
/*
 * Combinational round logic followed by data space write saturation.
 * Assumes the caller registers the result; reads the accumulator only.
 */
`timescale 1ns/1ps
`include "dacss_defs.vh"

module dacss_round_sat (
    input wire [`DACSS_ACC_W-1:0] acc_in,
    input wire round_en,
    input wire round_mode_select,
    input wire data_write_saturate_enable,
    output reg [`DACSS_WORD_W-1:0] word_out,
    output wire round_ovf,
    output wire sat_hit
);
    wire [15:0] low_word;
    wire half_exact;
    wire inc;
    wire [24:0] sum;
    wire [23:0] rounded;
    wire sign;
    wire out_of_range;

    assign low_word = acc_in[15:0];
    assign half_exact = (low_word == `DACSS_ROUND_HALF);
    // convergent mode only differs on an exact half: then bit 16 decides
    assign inc = round_en & low_word[15] &
                 (~round_mode_select | ~half_exact | acc_in[`DACSS_HI_LSB]);
    assign sum = {1'b0, acc_in[`DACSS_ACC_SIGN_BIT:`DACSS_HI_LSB]} + {24'h000000, inc};
    assign rounded = sum[23:0];
    assign sign = acc_in[`DACSS_ACC_SIGN_BIT];
    // a positive source that the round adder carried into bit 23 has wrapped
    assign round_ovf = ~sign & rounded[`DACSS_RANGE_MSB];
    assign out_of_range = round_ovf |
        (rounded[`DACSS_RANGE_MSB:`DACSS_RANGE_LSB] != {9{sign}});
    assign sat_hit = data_write_saturate_enable & out_of_range;

    always @* begin
        word_out = rounded[15:0];
        if (sat_hit) begin
            word_out = sign ? `DACSS_SAT_NEG : `DACSS_SAT_POS;
        end
    end
endmodule // dacss_round_sat

// File: rtl/dacss_top.v
/*
 * Accumulator store path and 40-bit barrel shifter of the signal
 * processing engine: stores, multiply-accumulate write-back with the
 * write-back pointer, round, write saturation and single-cycle shifts.
 * Assumes instruction decode presents one operation per cycle with
 * op_valid, synchronous to clock, and takes X bus writes from the
 * registered outputs one cycle later.
 */
`timescale 1ns/1ps
`include "dacss_defs.vh"

// Overview of operation
// - mac-class ops except multiply, negated, distance forms may write back
// - direct write-back puts rounded non-target high word into pointer register
// - post-increment write-back stores at pointer address, then pointer plus two
// - round is combinational, conventional or convergent by round mode select
// - without rounding, high word is stored truncated, low word dropped
// - conventional: low word 0x8000..0xFFFF increments high word, else unchanged
// - convergent: low word exactly 0x8000 increments only if bit 16 set
// - truncating and rounding stores write target accumulator through saturation
// - mac-class write-back is always rounded before saturation
// - round logic hands the 24-bit rounded accumulator bits 39..16 to saturation
// - write saturation changes memory and pointer write-back data only, never the accumulator
// - saturation uses source and round adder overflow to pick output
// - saturating, input above 0x007FFF becomes 0x7FFF
// - saturating, input below 0xFF8000 becomes 0x8000
// - operand sign comes from accumulator bit 39
// - saturation disabled passes the value unchanged
// - single-cycle shifts up to 16 right or left from accumulator or X bus
// - signed amount: positive right, negative left, zero unchanged
// - 40-bit datapath: 40-bit accumulator result, 16-bit general result
// - X data enters at bits 16..31 for right, 0..15 for left shifts
module dacss_top #(
    parameter ACC_W = `DACSS_ACC_W,
    parameter WORD_W = `DACSS_WORD_W
) (
    input wire clock,
    input wire rst_n,
    input wire op_valid,
    input wire [`DACSS_OP_W-1:0] op_code,
    input wire acc_sel,
    input wire wb_request,
    input wire wb_mode,
    input wire [ACC_W-1:0] acc_a,
    input wire [ACC_W-1:0] acc_b,
    input wire [WORD_W-1:0] xbus_rdata,
    input wire [WORD_W-1:0] store_addr,
    input wire round_mode_select,
    input wire data_write_saturate_enable,
    input wire [`DACSS_SHAMT_W-1:0] shift_amount,
    input wire shift_arith,
    input wire ptr_load,
    input wire [WORD_W-1:0] ptr_load_data,
    output reg [WORD_W-1:0] writeback_pointer_reg_q,
    output reg xbus_wr_q,
    output reg [WORD_W-1:0] xbus_waddr_q,
    output reg [WORD_W-1:0] xbus_wdata_q,
    output reg store_sat_q,
    output reg round_ovf_q,
    output reg wb_refused_q,
    output reg [ACC_W-1:0] shift_acc_q,
    output reg [WORD_W-1:0] shift_word_q,
    output reg shift_done_q
);

    // clamps a signed amount to a magnitude of at most sixteen
    function [5:0] shift_mag;
        input [5:0] amt;
        reg [5:0] m;
        begin
            m = amt[5] ? (6'h00 - amt) : amt;
            if (m > `DACSS_SHIFT_MAX) begin
                m = `DACSS_SHIFT_MAX;
            end
            shift_mag = m;
        end
    endfunction

    // one 40-bit barrel shift, used for both accumulator and X bus sources
    function [39:0] shift40;
        input [39:0] v;
        input [5:0] amt;
        input arith;
        reg [5:0] m;
        begin
            m = shift_mag(amt);
            if (amt == 6'h00) begin
                shift40 = v;
            end else if (!amt[5]) begin
                if (arith) begin
                    shift40 = $signed(v) >>> m;
                end else begin
                    shift40 = v >> m;
                end
            end else begin
                shift40 = v << m;
            end
        end
    endfunction

    reg [ACC_W-1:0] store_src;
    reg store_round;
    reg do_store;
    reg do_wb;
    reg is_excluded;
    reg [ACC_W-1:0] x_operand;
    reg [ACC_W-1:0] shift_src;
    reg [ACC_W-1:0] shift_res;
    reg [WORD_W-1:0] ptr_d;
    reg wr_d;
    reg [WORD_W-1:0] waddr_d;
    reg [WORD_W-1:0] wdata_d;
    wire [WORD_W-1:0] store_word;
    wire store_ovf;
    wire store_sat;
    wire [ACC_W-1:0] target_acc;
    wire [ACC_W-1:0] other_acc;

    assign target_acc = acc_sel ? acc_b : acc_a;
    assign other_acc = acc_sel ? acc_a : acc_b;

    // operation decode
    always @* begin
        is_excluded = 1'b0;
        do_store = 1'b0;
        do_wb = 1'b0;
        store_round = 1'b0;
        store_src = target_acc;
        if (op_valid) begin
            case (op_code)
                `DACSS_OP_STORE_TRUNC: begin
                    do_store = 1'b1;
                    store_round = 1'b0;
                end
                `DACSS_OP_STORE_ROUND: begin
                    do_store = 1'b1;
                    store_round = 1'b1;
                end
                `DACSS_OP_MAC: begin
                    do_wb = wb_request;
                    store_round = 1'b1;
                    store_src = other_acc;
                end
                `DACSS_OP_PLAIN_MULTIPLY,
                `DACSS_OP_NEGATED_MULTIPLY,
                `DACSS_OP_SQUARED_DISTANCE,
                `DACSS_OP_SQUARED_DISTANCE_ACC: begin
                    is_excluded = wb_request;
                end
                default: begin
                    is_excluded = 1'b0;
                end
            endcase
        end
    end

    // the accumulators are inputs only, so saturating a store cannot touch them
    dacss_round_sat u_round_sat (
        .acc_in(store_src),
        .round_en(store_round),
        .round_mode_select(round_mode_select),
        .data_write_saturate_enable(data_write_saturate_enable),
        .word_out(store_word),
        .round_ovf(store_ovf),
        .sat_hit(store_sat)
    );

    // write-back pointer and X bus write selection
    always @* begin
        ptr_d = writeback_pointer_reg_q;
        wr_d = 1'b0;
        waddr_d = xbus_waddr_q;
        wdata_d = xbus_wdata_q;
        // a core load loses to a write-back in the same cycle
        if (ptr_load) begin
            ptr_d = ptr_load_data;
        end
        if (do_store) begin
            wr_d = 1'b1;
            waddr_d = store_addr;
            wdata_d = store_word;
        end else if (do_wb) begin
            if (wb_mode == `DACSS_WB_DIRECT) begin
                ptr_d = store_word;
            end else begin
                wr_d = 1'b1;
                waddr_d = writeback_pointer_reg_q;
                wdata_d = store_word;
                ptr_d = writeback_pointer_reg_q + `DACSS_PTR_STEP;
            end
        end
    end

    // X bus data lands at bits 31:16 for right shifts, 15:0 for left shifts
    always @* begin
        if (!shift_amount[5]) begin
            x_operand = {{8{shift_arith & xbus_rdata[15]}}, xbus_rdata,
                         16'h0000};
        end else begin
            x_operand = {24'h000000, xbus_rdata};
        end
        if (op_code == `DACSS_OP_SHIFT_XBUS) begin
            shift_src = x_operand;
        end else begin
            shift_src = target_acc;
        end
        shift_res = shift40(shift_src, shift_amount, shift_arith);
    end

    // pointer register
    always @(posedge clock) begin
        if (!rst_n) begin
            writeback_pointer_reg_q <= `DACSS_PTR_RESET;
        end else begin
            writeback_pointer_reg_q <= ptr_d;
        end
    end

    // X bus write port, one-cycle strobe with held address and data
    always @(posedge clock) begin
        if (!rst_n) begin
            xbus_wr_q <= 1'b0;
            xbus_waddr_q <= 16'h0000;
            xbus_wdata_q <= 16'h0000;
        end else begin
            xbus_wr_q <= wr_d;
            xbus_waddr_q <= waddr_d;
            xbus_wdata_q <= wdata_d;
        end
    end

    // status of the most recent store or write-back, held until the next one
    always @(posedge clock) begin
        if (!rst_n) begin
            store_sat_q <= 1'b0;
            round_ovf_q <= 1'b0;
        end else if (do_store | do_wb) begin
            store_sat_q <= store_sat;
            round_ovf_q <= store_ovf;
        end
    end

    // a write-back asked of a multiply, negated or distance op is dropped and flagged
    always @(posedge clock) begin
        if (!rst_n) begin
            wb_refused_q <= 1'b0;
        end else begin
            wb_refused_q <= is_excluded;
        end
    end

    // shifter results, each held until the next shift of its own source; done strobe lasts one cycle
    always @(posedge clock) begin
        if (!rst_n) begin
            shift_acc_q <= 40'h0000000000;
            shift_word_q <= 16'h0000;
            shift_done_q <= 1'b0;
        end else begin
            shift_done_q <= 1'b0;
            if (op_valid && op_code == `DACSS_OP_SHIFT_ACC) begin
                shift_acc_q <= shift_res;
                shift_done_q <= 1'b1;
            end else if (op_valid && op_code == `DACSS_OP_SHIFT_XBUS) begin
                shift_done_q <= 1'b1;
                if (!shift_amount[5]) begin
                    shift_word_q <= shift_res[31:16];
                end else begin
                    shift_word_q <= shift_res[15:0];
                end
            end
        end
    end

endmodule // dacss_top

// File: sim/dacss_top_sva.sv
/*
 * Checker for the accumulator store path and barrel shifter ports.
 * Assumes it is bound into dacss_top and sees only that module's ports.
 */
`timescale 1ns/1ps
`include "dacss_defs.vh"

module dacss_top_sva #(
    parameter ACC_W = 40,
    parameter WORD_W = 16
) (
    input wire clock,
    input wire rst_n,
    input wire op_valid,
    input wire [3:0] op_code,
    input wire acc_sel,
    input wire wb_request,
    input wire wb_mode,
    input wire [ACC_W-1:0] acc_a,
    input wire [ACC_W-1:0] acc_b,
    input wire [WORD_W-1:0] store_addr,
    input wire data_write_saturate_enable,
    input wire [5:0] shift_amount,
    input wire ptr_load,
    input wire [WORD_W-1:0] writeback_pointer_reg_q,
    input wire xbus_wr_q,
    input wire [WORD_W-1:0] xbus_waddr_q,
    input wire [WORD_W-1:0] xbus_wdata_q,
    input wire wb_refused_q,
    input wire [ACC_W-1:0] shift_acc_q,
    input wire shift_done_q
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);
    wire [ACC_W-1:0] tgt = acc_sel ? acc_b : acc_a;
    wire st = op_valid && (op_code == `DACSS_OP_STORE_TRUNC || op_code == `DACSS_OP_STORE_ROUND);
    wire pi = op_valid && op_code == `DACSS_OP_MAC && wb_request && wb_mode;
    wire tr = op_valid && op_code == `DACSS_OP_STORE_TRUNC && data_write_saturate_enable;
    wire mul = op_valid && op_code >= `DACSS_OP_PLAIN_MULTIPLY && op_code <= 4'h7;
    wire sh = op_valid && (op_code == `DACSS_OP_SHIFT_ACC || op_code == `DACSS_OP_SHIFT_XBUS);

    wr_cause_a: assert property (xbus_wr_q |-> $past(st || pi))
        else $error("bus write without a store or write-back");
    store_addr_a: assert property (st |=> xbus_wr_q && xbus_waddr_q == $past(store_addr))
        else $error("store address not on bus");
    postinc_a: assert property (pi |=> xbus_wr_q &&
        xbus_waddr_q == $past(writeback_pointer_reg_q) &&
        writeback_pointer_reg_q == $past(writeback_pointer_reg_q) + 16'h0002)
        else $error("post-increment write-back wrong");
    sat_pos_a: assert property (
        tr && !tgt[39] && tgt[38:31] != 8'h00 |=> xbus_wdata_q == 16'h7FFF)
        else $error("positive saturation missing");
    sat_neg_a: assert property (
        tr && tgt[39] && tgt[38:31] != 8'hFF |=> xbus_wdata_q == 16'h8000)
        else $error("negative saturation missing");
    trunc_pass_a: assert property (
        st && op_code == `DACSS_OP_STORE_TRUNC && !data_write_saturate_enable
        |=> xbus_wdata_q == $past(tgt[31:16]))
        else $error("truncated store word wrong");
    refuse_a: assert property (mul && wb_request |=> wb_refused_q && !xbus_wr_q)
        else $error("write-back not refused");
    shift_zero_a: assert property (
        sh && op_code == `DACSS_OP_SHIFT_ACC && shift_amount == 6'h00
        |=> shift_done_q && shift_acc_q == $past(tgt))
        else $error("zero shift changed operand");
    ptr_hold_a: assert property (!$stable(writeback_pointer_reg_q)
        |-> $past(ptr_load || (op_valid && op_code == `DACSS_OP_MAC && wb_request)))
        else $error("pointer changed without cause");

    cover property (pi);
    cover property (mul && wb_request);
    cover property (tr);
    cover property (sh && shift_amount[5]);
endmodule // dacss_top_sva

bind dacss_top dacss_top_sva #(.ACC_W(ACC_W), .WORD_W(WORD_W)) u_sva (.*);

// File: sim/dacss_xbus_model.sv
/*
 * Word memory on the X data bus, written by the store path.
 * Assumes one write strobe per word, with the byte address in the address.
 */
`timescale 1ns/1ps

module dacss_xbus_model (
    input wire clock,
    input wire xbus_wr_q,
    input wire [15:0] xbus_waddr_q,
    input wire [15:0] xbus_wdata_q,
    input wire [15:0] rd_addr,
    output wire [15:0] rd_data
);
    reg [15:0] mem_q [0:255];
    // word wide, so address bit 0 never selects
    always @(posedge clock) begin
        if (xbus_wr_q) begin
            mem_q[xbus_waddr_q[8:1]] <= xbus_wdata_q;
        end
    end
    assign rd_data = mem_q[rd_addr[8:1]];
endmodule // dacss_xbus_model

// File: sim/tb.sv
/*
 * Self-checking bench for the accumulator store path and shifter.
 * Assumes the design header is on the include path.
 */
`timescale 1ns/1ps
`include "dacss_defs.vh"

module tb;
    reg clock = 1'b0;
    reg rst_n = 1'b0;
    reg op_valid = 1'b0;
    reg [3:0] op_code = 4'h0;
    reg acc_sel = 1'b0;
    reg wb_request = 1'b0;
    reg wb_mode = 1'b0;
    reg [39:0] acc_a = 40'h0;
    reg [39:0] acc_b = 40'h0;
    reg [15:0] xbus_rdata = 16'h0;
    reg [15:0] store_addr = 16'h0;
    reg round_mode_select = 1'b0;
    reg data_write_saturate_enable = 1'b0;
    reg [5:0] shift_amount = 6'h0;
    reg shift_arith = 1'b0;
    reg ptr_load = 1'b0;
    reg [15:0] ptr_load_data = 16'h0;
    reg [15:0] rd_addr = 16'h0100;
    wire [15:0] writeback_pointer_reg_q, xbus_waddr_q, xbus_wdata_q, shift_word_q, mem_word;
    wire [39:0] shift_acc_q;
    wire xbus_wr_q, store_sat_q, round_ovf_q, wb_refused_q, shift_done_q;
    integer bad_count = 0, check_count = 0, seed = 87, i;
    reg [15:0] ptr_m = 16'h0;
    reg [40:0] wq[$], sq[$], e;
    reg [39:0] sv [0:5];
    reg [31:0] r;

    dacss_top dut (.*);
    dacss_xbus_model u_xbus (.clock(clock), .xbus_wr_q(xbus_wr_q), .xbus_waddr_q(xbus_waddr_q),
        .xbus_wdata_q(xbus_wdata_q), .rd_addr(rd_addr), .rd_data(mem_word));

    always #10 clock = ~clock;

    task chk(input [8*10:1] n, input [40:0] x, input [40:0] g);
        begin
            check_count = check_count + 1;
            if (x !== g) begin
                bad_count = bad_count + 1;
                $display("MISMATCH %0s expected %h seen %h", n, x, g);
            end
        end
    endtask

    // returns {saturated, word}
    function [16:0] rw(input [39:0] a, input rnd, input md, input st);
        reg [24:0] s;
        reg o;
        begin
            s = {a[39], a[39:16]} + (rnd & a[15] & (!md | (|a[14:0]) | a[16]));
            o = st && ($signed(s) > 25'sh7FFF || $signed(s) < -25'sh8000);
            rw = {o, o ? (a[39] ? 16'h8000 : 16'h7FFF) : s[15:0]};
        end
    endfunction

    function [39:0] sh(input [39:0] v, input [5:0] n, input ar);
        reg [5:0] m;
        begin
            m = n[5] ? -n : n;
            if (n[5]) sh = v << m;
            else if (ar) sh = $signed(v) >>> m;
            else sh = v >> m;
        end
    endfunction

    // f: sel, mode, sat, arith, wb request, wb mode from bit 0 up
    task op(input [3:0] c, input [39:0] a, input [15:0] x, input [5:0] n, input [31:0] f);
        reg [39:0] t, v;
        reg [16:0] w;
        begin
            {wb_mode, wb_request, shift_arith, data_write_saturate_enable, round_mode_select,
                acc_sel} = f[5:0];
            op_valid = 1'b1;
            op_code = c;
            acc_a = a;
            acc_b = ~a;
            xbus_rdata = x;
            store_addr = x;
            shift_amount = n;
            t = f[0] ? ~a : a;
            w = rw(f[0] ? a : ~a, 1'b1, f[1], f[2]);
            v = sh(n[5] ? {24'h0, x} : {(f[3] ? {8{x[15]}} : 8'h00), x, 16'h0}, n, f[3]);
            if (c == 1 || c == 2) wq.push_back({rw(t, c == 2, f[1], f[2]), x});
            if (c == 3 && f[4] && f[5]) wq.push_back({w, ptr_m});
            if (c == 3 && f[4] && f[5]) ptr_m = ptr_m + 16'h0002;
            if (c == 8) sq.push_back({1'b0, sh(t, n, f[3])});
            if (c == 9) sq.push_back({25'h1000000, n[5] ? v[15:0] : v[31:16]});
            @(posedge clock);
            #1;
            if (c == 3 && f[4] && !f[5]) chk("pointer", w[15:0], writeback_pointer_reg_q);
            if (c == 3 && f[4] && !f[5]) ptr_m = w[15:0];
            if (c >= 4 && c <= 7 && f[4]) chk("refused", 1, wb_refused_q);
        end
    endtask

    always @(posedge clock) begin
        if (rst_n && xbus_wr_q === 1'b1) begin
            e = wq.size() ? wq.pop_front() : 41'h1FFFFFFFFFF;
            chk("xbus_write", e, {store_sat_q, xbus_wdata_q, xbus_waddr_q});
        end
        if (rst_n && shift_done_q === 1'b1) begin
            e = sq.size() ? sq.pop_front() : 41'h1FFFFFFFFFF;
            chk("shift", e, e[40] ? {25'h1000000, shift_word_q} : {1'b0, shift_acc_q});
        end
    end

    task conclude;
        begin
            $display("comparisons %0d mismatches %0d", check_count, bad_count);
            if (bad_count == 0 && check_count > 0) $display("SIMULATION PASSED");
            else $display("SIMULATION FAILED");
            $finish;
        end
    endtask

    initial begin
        #100000;
        bad_count = bad_count + 1;
        conclude;
    end

    initial begin
        sv[0] = 40'h007FFF7FFF;
        sv[1] = 40'h007FFF8000;
        sv[2] = 40'h0080000000;
        sv[3] = 40'hFF80000000;
        sv[4] = 40'hFF7FFFFFFF;
        sv[5] = 40'h8000000000;
        repeat (16) @(posedge clock);
        #1;
        chk("reset", 0, {xbus_wr_q, wb_refused_q, shift_done_q, writeback_pointer_reg_q});
        rst_n = 1'b1;
        ptr_load = 1'b1;
        ptr_load_data = 16'h0100;
        @(posedge clock);
        #1;
        ptr_load = 1'b0;
        ptr_m = 16'h0100;
        chk("pointer", ptr_m, writeback_pointer_reg_q);
        // convergent ties back to back: even high word stays, odd one goes up
        op(4'h3, 40'h0012348000, 16'h0, 6'h0, 32'h33);
        op(4'h3, 40'h0012358000, 16'h0, 6'h0, 32'h33);
        op(4'h3, 40'h0040000000, 16'h0, 6'h0, 32'h13);
        for (i = 4; i < 8; i = i + 1) op(i[3:0], sv[i - 2], 16'h0, 6'h0, 32'h10);
        op_valid = 1'b0;
        chk("memory", 16'h1234, mem_word);
        for (i = 0; i < 48; i = i + 1) op(4'h1 + i[3], sv[i % 6], i[15:0], 6'h0, $random(seed));
        for (i = 0; i < 128; i = i + 1) begin
            op(4'h1 + i[3], {23'h00091A, i[2], i[1], {15{i[0]}}}, 16'h0200, 6'h0, $random(seed));
        end
        for (i = 0; i < 132; i = i + 1) begin
            r = $random(seed);
            op(4'h8 + i[0], {r[7:0], $random(seed)}, r[31:16], i[7:2] - 6'h10, r);
        end
        for (i = 0; i < 200; i = i + 1) begin
            r = $random(seed);
            op(r[3:0] % 4'hA, i[0] ? {{8{r[31]}}, r} : {r[7:0], $random(seed)}, r[31:16],
                r[9] ? 6'h00 - {2'b00, r[13:10]} : {2'b00, r[13:10]}, $random(seed));
        end
        op_valid = 1'b0;
        repeat (3) @(posedge clock);
        #1;
        chk("pending", 0, wq.size() + sq.size());
        chk("pointer", ptr_m, writeback_pointer_reg_q);
        conclude;
    end
endmodule // tb
